//--- szi_pkg.sv
// constants and types shared by the zone interlock scanner logic
package szi_pkg;
    // clock and scan timing
    localparam int CLK_PERIOD_NS   = 4;
    localparam int STEP_TIME_NS    = 1000;
    localparam int STEP_CYCLES     = STEP_TIME_NS / CLK_PERIOD_NS;
    localparam int STEP_CDEG       = 36;
    localparam int SECTOR_CDEG     = 19000;
    localparam int STEPS_PER_SCAN  = SECTOR_CDEG / STEP_CDEG + 1;
    localparam int LIGHT_MM_PER_US = 299792;
    localparam int MM_PER_CYCLE    = LIGHT_MM_PER_US * CLK_PERIOD_NS / 2000;
    localparam int NUM_PAIRS       = 4;

    // register indices on the plain register port
    localparam logic [3:0] ADDR_CTRL  = 4'h0;
    localparam logic [3:0] ADDR_STAT  = 4'h1;
    localparam logic [3:0] ADDR_MASK  = 4'h2;
    localparam logic [3:0] ADDR_STATE = 4'h3;
    localparam logic [3:0] ADDR_DZ0   = 4'h4;
    localparam logic [3:0] ADDR_WZ0   = 4'h8;

    // reset values
    localparam logic [15:0] CTRL_RST = 16'h0001;
    localparam logic [15:0] DZ_RST   = 16'h07D0;
    localparam logic [15:0] WZ_RST   = 16'h0FA0;
    localparam logic [1:0]  PAIR_RST = 2'h0;

    // control byte fields
    localparam int CB_ZONE_LSB = 0;
    localparam int CB_PROXY    = 6;
    // status byte fields
    localparam int SB_PAIR_LSB = 0;
    localparam int SB_ZFAULT   = 3;
    localparam int SB_WARN     = 5;
    localparam int SB_DET      = 6;
    localparam int SB_SAFE     = 7;
    // control register bit
    localparam int CTRL_SCAN_EN = 0;
    // event bits of status and mask registers
    localparam int EV_DET    = 0;
    localparam int EV_WARN   = 1;
    localparam int EV_ZFAULT = 2;
    localparam int EV_SCAN   = 3;
    localparam int EV_W      = 4;

    typedef enum logic [1:0] {
        SC_IDLE = 2'b01,
        SC_WAIT = 2'b10
    } szi_scan_e;
endpackage

//--- szi_scan_if.sv
// link between the interlock core and the pulse ranging engine
`timescale 1ns/100ps
interface szi_scan_if;
    logic        enable;
    logic        dist_valid;
    logic        echo_hit;
    logic [15:0] dist_mm;
    logic        scan_end;

    modport ctrl (output enable, input dist_valid, echo_hit, dist_mm,
                  scan_end);
    modport scan (input enable, output dist_valid, echo_hit, dist_mm,
                  scan_end);
endinterface

//--- szi_scan.sv
// pulse ranging engine: one laser shot per angular step, time of flight
`timescale 1ns/100ps
module szi_scan #(
    parameter int STEP_CYCLES = szi_pkg::STEP_CYCLES,
    parameter int STEPS       = szi_pkg::STEPS_PER_SCAN
) (
    input  wire logic mclk,
    input  wire logic arst_n,
    input  wire logic echo_in,
    output logic      laser_pulse,
    szi_scan_if.scan  sif
);
    szi_pkg::szi_scan_e st_reg, st_next;
    logic [11:0] div_reg,   div_next;
    logic [9:0]  angle_reg, angle_next;
    logic [11:0] tof_reg,   tof_next;
    logic        laser_reg, laser_next;
    logic        dv_reg,    dv_next;
    logic        hit_reg,   hit_next;
    logic        end_reg,   end_next;
    logic [15:0] dist_reg,  dist_next;
    logic [23:0] prod;
    logic        tick;
    logic        done;

    // distance is half the round trip; saturate beyond 16 bits
    assign prod = 24'(tof_reg) * 24'(szi_pkg::MM_PER_CYCLE);

    always_comb begin
        st_next    = st_reg;
        div_next   = div_reg;
        angle_next = angle_reg;
        tof_next   = tof_reg;
        laser_next = 1'b0;
        dv_next    = 1'b0;
        end_next   = 1'b0;
        hit_next   = hit_reg;
        dist_next  = dist_reg;
        done       = 1'b0;
        tick       = sif.enable && (div_reg == 12'(STEP_CYCLES - 1));
        div_next   = (!sif.enable || tick) ? 12'h000 : div_reg + 12'h001;
        case (st_reg)
            szi_pkg::SC_IDLE: begin
                if (tick) begin
                    laser_next = 1'b1;
                    tof_next   = 12'h000;
                    st_next    = szi_pkg::SC_WAIT;
                end
            end
            szi_pkg::SC_WAIT: begin
                tof_next = tof_reg + 12'h001;
                if (echo_in) begin
                    done      = 1'b1;
                    hit_next  = 1'b1;
                    dist_next = (prod[23:16] != 8'h00) ? 16'hFFFF
                                                      : prod[15:0];
                end else if (tof_reg == 12'(STEP_CYCLES - 2)) begin
                    // no echo before the next shot: nothing in range
                    done      = 1'b1;
                    hit_next  = 1'b0;
                    dist_next = 16'hFFFF;
                end
            end
            default: st_next = szi_pkg::SC_IDLE;
        endcase
        if (done) begin
            dv_next = 1'b1;
            st_next = szi_pkg::SC_IDLE;
            if (angle_reg == 10'(STEPS - 1)) begin
                angle_next = 10'h000;
                end_next   = 1'b1;
            end else begin
                angle_next = angle_reg + 10'h001;
            end
        end
        if (!sif.enable) begin
            st_next    = szi_pkg::SC_IDLE;
            angle_next = 10'h000;
        end
    end

    // state registers
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg    <= szi_pkg::SC_IDLE;
            div_reg   <= 12'h000;
            angle_reg <= 10'h000;
            tof_reg   <= 12'h000;
            laser_reg <= 1'b0;
            dv_reg    <= 1'b0;
            hit_reg   <= 1'b0;
            end_reg   <= 1'b0;
            dist_reg  <= 16'hFFFF;
        end else begin
            st_reg    <= st_next;
            div_reg   <= div_next;
            angle_reg <= angle_next;
            tof_reg   <= tof_next;
            laser_reg <= laser_next;
            dv_reg    <= dv_next;
            hit_reg   <= hit_next;
            end_reg   <= end_next;
            dist_reg  <= dist_next;
        end
    end

    assign laser_pulse    = laser_reg;
    assign sif.dist_valid = dv_reg;
    assign sif.echo_hit   = hit_reg;
    assign sif.dist_mm    = dist_reg;
    assign sif.scan_end   = end_reg;
endmodule

//--- szi_core.sv
// zone interlock scanner core: zone pairs, status byte, registers
//
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/100ps
module szi_core #(
    parameter int STEP_CYCLES = szi_pkg::STEP_CYCLES,
    parameter int STEPS       = szi_pkg::STEPS_PER_SCAN,
    parameter int NUM_PAIRS   = szi_pkg::NUM_PAIRS
) (
    input  wire logic        mclk,
    input  wire logic        arst_n,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    input  wire logic        ctrl_valid,
    input  wire logic [7:0]  ctrl_byte,
    output logic             status_valid,
    output logic      [7:0]  status_byte,
    input  wire logic        echo_in,
    output logic             laser_pulse,
    output logic             irq
);
    localparam int EVW = szi_pkg::EV_W;

    szi_scan_if sif ();

    logic [15:0]    ctrl_reg,  ctrl_next;
    logic [EVW-1:0] mask_reg,  mask_next;
    logic [EVW-1:0] stat_reg,  stat_next;
    logic [15:0]    dz_reg [NUM_PAIRS];
    logic [15:0]    wz_reg [NUM_PAIRS];
    logic [1:0]     pair_reg,  pair_next;
    logic           zf_reg,    zf_next;
    logic           safe_reg,  safe_next;
    logic           det_reg,   det_next;
    logic           warn_reg,  warn_next;
    logic           dacc_reg,  dacc_next;
    logic           wacc_reg,  wacc_next;
    logic           sv_reg,    sv_next;
    logic [7:0]     sb_reg,    sb_next;
    logic [15:0]    rd_reg,    rd_next;
    logic [EVW-1:0] events;
    logic [2:0]     zone_num;
    logic           zone_ok;
    logic           zone_evt;
    logic           det_now;
    logic           warn_now;

    // ranging engine, enabled from the control register
    szi_scan #(
        .STEP_CYCLES (STEP_CYCLES),
        .STEPS       (STEPS)
    ) u_scan (
        .mclk        (mclk),
        .arst_n      (arst_n),
        .echo_in     (echo_in),
        .laser_pulse (laser_pulse),
        .sif         (sif.scan)
    );

    assign sif.enable = ctrl_reg[szi_pkg::CTRL_SCAN_EN];

    // per pair contour limits, written over the register port
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PAIRS; gi++) begin : g_pair
            logic [15:0] dz_next;
            logic [15:0] wz_next;
            always_comb begin
                dz_next = dz_reg[gi];
                wz_next = wz_reg[gi];
                if (reg_wr && reg_addr == szi_pkg::ADDR_DZ0 + 4'(gi)) begin
                    dz_next = reg_wdata;
                end
                if (reg_wr && reg_addr == szi_pkg::ADDR_WZ0 + 4'(gi)) begin
                    wz_next = reg_wdata;
                end
            end
            always_ff @(posedge mclk or negedge arst_n) begin
                if (!arst_n) begin
                    dz_reg[gi] <= szi_pkg::DZ_RST;
                    wz_reg[gi] <= szi_pkg::WZ_RST;
                end else begin
                    dz_reg[gi] <= dz_next;
                    wz_reg[gi] <= wz_next;
                end
            end
        end
    endgenerate

    // control byte taken only on a bus cycle
    assign zone_num = ctrl_byte[szi_pkg::CB_ZONE_LSB +: 3];
    // a pair outside 1..4 or proxy selection cannot be honoured here
    assign zone_ok  = (zone_num >= 3'h1) && (zone_num <= 3'(NUM_PAIRS))
                      && !ctrl_byte[szi_pkg::CB_PROXY];
    assign zone_evt = ctrl_valid && !zone_ok;

    // single active pair, kept on a bad request
    always_comb begin
        pair_next = pair_reg;
        zf_next   = zf_reg;
        if (ctrl_valid) begin
            zf_next = !zone_ok;
            if (zone_ok) begin
                pair_next = 2'(zone_num - 3'h1);
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pair_reg <= szi_pkg::PAIR_RST;
            zf_reg   <= 1'b0;
        end else begin
            pair_reg <= pair_next;
            zf_reg   <= zf_next;
        end
    end

    // hits against the active pair's two contours
    assign det_now  = sif.dist_valid && sif.echo_hit
                      && (sif.dist_mm < dz_reg[pair_reg]);
    assign warn_now = sif.dist_valid && sif.echo_hit
                      && (sif.dist_mm < wz_reg[pair_reg]);

    // safe bit drops at once, returns after a clear scan
    // re-arming only at scan end avoids chatter at a contour edge
    always_comb begin
        safe_next = safe_reg;
        det_next  = det_reg;
        warn_next = warn_reg;
        dacc_next = dacc_reg | det_now;
        wacc_next = wacc_reg | warn_now;
        if (det_now) begin
            safe_next = 1'b0;
            det_next  = 1'b1;
        end
        if (warn_now) begin
            warn_next = 1'b1;
        end
        if (sif.scan_end) begin
            safe_next = !(dacc_reg | det_now);
            det_next  = dacc_reg | det_now;
            warn_next = wacc_reg | warn_now;
            dacc_next = 1'b0;
            wacc_next = 1'b0;
        end
        // a stopped scanner cannot vouch for the zone
        if (!sif.enable) begin
            safe_next = 1'b0;
            dacc_next = 1'b0;
            wacc_next = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            safe_reg <= 1'b0;
            det_reg  <= 1'b0;
            warn_reg <= 1'b0;
            dacc_reg <= 1'b0;
            wacc_reg <= 1'b0;
        end else begin
            safe_reg <= safe_next;
            det_reg  <= det_next;
            warn_reg <= warn_next;
            dacc_reg <= dacc_next;
            wacc_reg <= wacc_next;
        end
    end

    // status byte snapshot answered for every control byte
    always_comb begin
        sv_next = ctrl_valid;
        sb_next = sb_reg;
        if (ctrl_valid) begin
            sb_next = 8'h00;
            sb_next[szi_pkg::SB_SAFE]   = safe_reg;
            sb_next[szi_pkg::SB_DET]    = det_reg;
            sb_next[szi_pkg::SB_WARN]   = warn_reg;
            sb_next[szi_pkg::SB_ZFAULT] = !zone_ok;
            sb_next[szi_pkg::SB_PAIR_LSB +: 3] = 3'(pair_next) + 3'h1;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            sv_reg <= 1'b0;
            sb_reg <= 8'h00;
        end else begin
            sv_reg <= sv_next;
            sb_reg <= sb_next;
        end
    end

    // event sources; a new event wins over a write-one clear
    always_comb begin
        events = '0;
        events[szi_pkg::EV_DET]    = safe_reg && !safe_next;
        events[szi_pkg::EV_WARN]   = !warn_reg && warn_next;
        events[szi_pkg::EV_ZFAULT] = zone_evt;
        events[szi_pkg::EV_SCAN]   = sif.scan_end;
    end

    // control, mask and sticky status registers
    always_comb begin
        ctrl_next = ctrl_reg;
        mask_next = mask_reg;
        stat_next = stat_reg;
        if (reg_wr && reg_addr == szi_pkg::ADDR_CTRL) begin
            ctrl_next = reg_wdata;
        end
        if (reg_wr && reg_addr == szi_pkg::ADDR_MASK) begin
            mask_next = reg_wdata[EVW-1:0];
        end
        if (reg_wr && reg_addr == szi_pkg::ADDR_STAT) begin
            stat_next = stat_reg & ~reg_wdata[EVW-1:0];
        end
        stat_next = stat_next | events;
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_reg <= szi_pkg::CTRL_RST;
            mask_reg <= '0;
            stat_reg <= '0;
        end else begin
            ctrl_reg <= ctrl_next;
            mask_reg <= mask_next;
            stat_reg <= stat_next;
        end
    end

    // read mux; unmapped addresses read zero
    always_comb begin
        rd_next = 16'h0000;
        if (reg_rd) begin
            case (reg_addr)
                szi_pkg::ADDR_CTRL:  rd_next = ctrl_reg;
                szi_pkg::ADDR_STAT:  rd_next = 16'(stat_reg);
                szi_pkg::ADDR_MASK:  rd_next = 16'(mask_reg);
                szi_pkg::ADDR_STATE: begin
                    rd_next[7]   = safe_reg;
                    rd_next[6]   = det_reg;
                    rd_next[5]   = warn_reg;
                    rd_next[3]   = zf_reg;
                    rd_next[1:0] = pair_reg;
                end
                default: begin
                    if (reg_addr >= szi_pkg::ADDR_DZ0
                        && reg_addr < szi_pkg::ADDR_DZ0 + 4'(NUM_PAIRS)) begin
                        rd_next = dz_reg[2'(reg_addr - szi_pkg::ADDR_DZ0)];
                    end else if (reg_addr >= szi_pkg::ADDR_WZ0
                        && reg_addr < szi_pkg::ADDR_WZ0 + 4'(NUM_PAIRS)) begin
                        rd_next = wz_reg[2'(reg_addr - szi_pkg::ADDR_WZ0)];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rd_reg <= 16'h0000;
        end else begin
            rd_reg <= rd_next;
        end
    end

    assign reg_rdata    = rd_reg;
    assign status_valid = sv_reg;
    assign status_byte  = sb_reg;
    assign irq          = |(stat_reg & mask_reg);
endmodule

//--- szi_checker.sv
// port assertions for the zone interlock core
`timescale 1ns/100ps
module szi_checker #(
    parameter int STEP_CYCLES = 8,
    parameter int STEPS       = 4
) (
    input wire logic        mclk,
    input wire logic        arst_n,
    input wire logic [3:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic        ctrl_valid,
    input wire logic [7:0]  ctrl_byte,
    input wire logic        status_valid,
    input wire logic [7:0]  status_byte,
    input wire logic        echo_in,
    input wire logic        laser_pulse,
    input wire logic        irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    logic [15:0] gap_reg;
    logic [15:0] gap_next;
    logic        seen_reg;
    logic        seen_next;
    wire logic   good_req = !ctrl_byte[6]
                            && ctrl_byte[2:0] inside {[3'h1:3'h4]};

    // cycles since the last shot; the first shot has no reference
    always_comb begin
        gap_next  = laser_pulse ? 16'h0001 : gap_reg + 16'h0001;
        seen_next = seen_reg | laser_pulse;
    end
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            gap_reg  <= 16'h0000;
            seen_reg <= 1'b0;
        end else begin
            gap_reg  <= gap_next;
            seen_reg <= seen_next;
        end
    end

    a_answer_next: assert property (ctrl_valid |=> status_valid)
        else $error("no status byte after a control byte");
    a_no_stray: assert property (!ctrl_valid |=> !status_valid)
        else $error("status byte without a control byte");
    a_status_holds: assert property (
        !status_valid |-> $stable(status_byte))
        else $error("status byte changed between answers");
    a_zone_taken: assert property (ctrl_valid && good_req |=>
        status_byte[2:0] == $past(ctrl_byte[2:0]) && !status_byte[3])
        else $error("requested zone pair not taken");
    a_bad_flag: assert property (
        ctrl_valid && !good_req |=> status_byte[3])
        else $error("bad zone request not flagged");
    a_pair_range: assert property (status_valid |->
        status_byte[2:0] inside {[3'h1:3'h4]} && !status_byte[4])
        else $error("active pair out of range");
    a_safe_det: assert property (
        status_valid && status_byte[6] |-> !status_byte[7])
        else $error("safe bit high with detection violated");
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data outside read answer");
    a_unmapped_zero: assert property (
        reg_rd && reg_addr >= 4'hC |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    a_step_gap: assert property (
        laser_pulse && seen_reg |-> gap_reg >= STEP_CYCLES)
        else $error("laser shots too close");

    c_bad_req: cover property (ctrl_valid && !good_req);
    c_detect: cover property (status_valid && status_byte[6]);
    c_warn: cover property (status_valid && status_byte[5] && status_byte[7]);
    c_irq: cover property ($rose(irq));
endmodule

//--- szi_ctrl_model.sv
// fail-safe controller model: bus master and actuator interlock
`timescale 1ns/100ps
module szi_ctrl_model #(
    parameter int BUS_GAP = 4
) (
    input  wire logic       mclk,
    input  wire logic       arst_n,
    input  wire logic [1:0] sens,
    input  wire logic       sens_fault,
    input  wire logic       start_no,
    input  wire logic       stop_nc,
    input  wire logic       ack,
    input  wire logic       raw_en,
    input  wire logic [7:0] raw_byte,
    input  wire logic       status_valid,
    input  wire logic [7:0] status_byte,
    output logic            ctrl_valid,
    output logic      [7:0] ctrl_byte,
    output logic            actuator
);
    int         tick;
    logic [2:0] zone;
    logic       safe_q;
    logic       need_ack;
    wire logic  zfault = sens_fault || (sens != 2'b01 && sens != 2'b10);

    // raw_en lets a scenario send a deliberately wrong byte
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            tick       <= 0;
            ctrl_valid <= 1'b0;
            ctrl_byte  <= 8'h01;
            zone       <= 3'h1;
            safe_q     <= 1'b0;
            need_ack   <= 1'b1;
            actuator   <= 1'b0;
        end else begin
            // one control byte per bus cycle
            tick       <= (tick == BUS_GAP - 1) ? 0 : tick + 1;
            ctrl_valid <= (tick == 0);
            // pair from sensors, proxy bit low
            if (tick == 0) begin
                ctrl_byte <= raw_en ? raw_byte : {5'h00, zone};
            end
            // undefined sensor mix keeps the old pair
            if (!zfault) begin
                zone <= sens[1] ? 3'h2 : 3'h1;
            end
            // only bit 7 counts, fall needs ack
            if (status_valid) begin
                safe_q <= status_byte[7];
                if (safe_q && !status_byte[7]) begin
                    need_ack <= 1'b1;
                end
            end
            if (ack) begin
                need_ack <= 1'b0;
            end
            // off on stop, fault, loss of clear
            if (!stop_nc || zfault || !safe_q
                || (status_valid && !status_byte[7])) begin
                actuator <= 1'b0;
            end else if (start_no && !need_ack) begin
                actuator <= 1'b1;
            end
        end
    end
endmodule

//--- tb_safety_zone_interlock.sv
// self-checking bench for the zone interlock core
`timescale 1ns/100ps
`define CHK(nm, exp, got) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) begin \
            mismatches++; \
            $display("ERROR %s expected %0h seen %0h", nm, exp, got); \
        end \
    end
module tb_safety_zone_interlock;
    logic        mclk;
    logic        arst_n;
    logic [3:0]  reg_addr;
    logic [15:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [15:0] reg_rdata;
    logic        ctrl_valid;
    logic [7:0]  ctrl_byte;
    logic        status_valid;
    logic [7:0]  status_byte;
    logic        echo_in;
    logic        laser_pulse;
    logic        irq;
    logic [1:0]  sens;
    logic        sens_fault;
    logic [1:0]  btn;
    logic        stop_nc;
    logic        raw_en;
    logic [7:0]  raw_byte;
    logic        actuator;
    int          echo_dly;
    int          comparisons;
    int          mismatches;

    // short scan so a full clear scan takes 32 cycles
    szi_core #(.STEP_CYCLES(8), .STEPS(4)) dut_u (
        .mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .ctrl_valid(ctrl_valid),
        .ctrl_byte(ctrl_byte), .status_valid(status_valid),
        .status_byte(status_byte), .echo_in(echo_in),
        .laser_pulse(laser_pulse), .irq(irq));
    szi_ctrl_model ctl_u (
        .mclk(mclk), .arst_n(arst_n), .sens(sens), .sens_fault(sens_fault),
        .start_no(btn[0]), .stop_nc(stop_nc), .ack(btn[1]),
        .raw_en(raw_en), .raw_byte(raw_byte), .status_valid(status_valid),
        .status_byte(status_byte), .ctrl_valid(ctrl_valid),
        .ctrl_byte(ctrl_byte), .actuator(actuator));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // object reflection: one echo per shot, echo_dly cycles later
    initial begin
        echo_in = 1'b0;
        forever begin
            @(posedge mclk);
            if (laser_pulse === 1'b1 && echo_dly > 0) begin
                repeat (echo_dly) @(posedge mclk);
                echo_in <= 1'b1;
                @(posedge mclk);
                echo_in <= 1'b0;
            end
        end
    end

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask

    task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic press(input logic [1:0] which);
        @(posedge mclk);
        btn <= which;
        repeat (8) @(posedge mclk);
        btn <= 2'b00;
    endtask

    // bounded wait on {actuator, status byte} under a mask
    task automatic wait_on(input logic [8:0] m, input logic [8:0] v);
        int n;
        n = 0;
        @(posedge mclk);
        #1;
        while (({actuator, status_byte} & m) !== v && n < 300) begin
            @(posedge mclk);
            #1;
            n++;
        end
        `CHK("actuator and status", v, {actuator, status_byte} & m)
        if (n >= 300) stop_test();
    endtask

    task automatic t_regs();
        logic [15:0] d;
        reg_read(szi_pkg::ADDR_CTRL, d);
        `CHK("ctrl reset", szi_pkg::CTRL_RST, d)
        for (int i = 0; i < 4; i++) begin
            reg_read(szi_pkg::ADDR_DZ0 + 4'(i), d);
            `CHK("detection limit reset", szi_pkg::DZ_RST, d)
            reg_read(szi_pkg::ADDR_WZ0 + 4'(i), d);
            `CHK("warning limit reset", szi_pkg::WZ_RST, d)
        end
        reg_write(4'hC, 16'hFFFF);
        reg_read(4'hC, d);
        `CHK("unmapped read", 16'h0000, d)
        $display("test regs done");
    endtask

    task automatic t_zone();
        logic [7:0] bad [5] = '{8'h00, 8'h05, 8'h06, 8'h07, 8'h42};
        raw_en <= 1'b1;
        for (int n = 1; n <= 4; n++) begin
            raw_byte <= 8'(n);
            wait_on(9'h00F, 9'(n));
        end
        reg_write(szi_pkg::ADDR_MASK, 16'h0004);
        foreach (bad[i]) begin
            raw_byte <= 8'h03;
            wait_on(9'h00F, 9'h003);
            raw_byte <= bad[i];
            wait_on(9'h00F, 9'h00B);
        end
        raw_byte <= 8'h03;
        wait_on(9'h00F, 9'h003);
        `CHK("irq on bad zone", 1'b1, irq)
        reg_write(szi_pkg::ADDR_STAT, 16'h0004);
        repeat (2) @(posedge mclk);
        #1;
        `CHK("irq after clear", 1'b0, irq)
        raw_en <= 1'b0;
        $display("test zone done");
    endtask

    task automatic t_detect();
        logic [15:0] d;
        wait_on(9'h080, 9'h080);
        press(2'b10);
        press(2'b01);
        wait_on(9'h100, 9'h100);
        echo_dly <= 1;
        wait_on(9'h0C0, 9'h040);
        wait_on(9'h100, 9'h000);
        reg_read(szi_pkg::ADDR_STAT, d);
        `CHK("detection event", 1'b1, d[szi_pkg::EV_DET])
        reg_read(szi_pkg::ADDR_STATE, d);
        `CHK("state safe det warn", 3'h3, d[7:5])
        echo_dly <= 0;
        wait_on(9'h0C0, 9'h080);
        press(2'b01);
        wait_on(9'h100, 9'h000);
        press(2'b10);
        press(2'b01);
        wait_on(9'h100, 9'h100);
        stop_nc <= 1'b0;
        wait_on(9'h100, 9'h000);
        stop_nc <= 1'b1;
        $display("test detect done");
    endtask

    task automatic t_warn();
        press(2'b01);
        wait_on(9'h100, 9'h100);
        reg_write(szi_pkg::ADDR_DZ0, 16'h0100);
        echo_dly <= 1;
        wait_on(9'h020, 9'h020);
        wait_on(9'h1C0, 9'h180);
        echo_dly <= 0;
        reg_write(szi_pkg::ADDR_DZ0, szi_pkg::DZ_RST);
        $display("test warn done");
    endtask

    task automatic t_fault();
        sens <= 2'b10;
        wait_on(9'h007, 9'h002);
        sens <= 2'b11;
        wait_on(9'h100, 9'h000);
        sens <= 2'b01;
        press(2'b01);
        wait_on(9'h100, 9'h100);
        sens_fault <= 1'b1;
        wait_on(9'h100, 9'h000);
        sens_fault <= 1'b0;
        reg_write(szi_pkg::ADDR_CTRL, 16'h0000);
        wait_on(9'h080, 9'h000);
        $display("test fault done");
    endtask

    initial begin
        arst_n = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        sens = 2'b01;
        sens_fault = 1'b0;
        btn = 2'b00;
        stop_nc = 1'b1;
        raw_en = 1'b0;
        raw_byte = 8'h01;
        echo_dly = 0;
        comparisons = 0;
        mismatches = 0;
        repeat (10) @(posedge mclk);
        arst_n <= 1'b1;
        t_regs();
        t_zone();
        t_detect();
        t_warn();
        t_fault();
        stop_test();
    end
endmodule

bind szi_core szi_checker #(.STEP_CYCLES(STEP_CYCLES), .STEPS(STEPS)) chk_u (
    .mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ctrl_valid(ctrl_valid), .ctrl_byte(ctrl_byte),
    .status_valid(status_valid), .status_byte(status_byte),
    .echo_in(echo_in), .laser_pulse(laser_pulse), .irq(irq));
